// >>> core/fpm_ctrl.sv
// front panel menu, reference selection and remote serial controller
// ============================================================================
// Overview of operation
// - serial link is 9600 baud, 8N1
// - session opens and closes via menu press
// - incomplete session discards all pending edits
// - thirty idle seconds abort session, restore settings
// - settings kept in nonvolatile store, reloaded
// - boot shows all segments, version, then status
// - horizontal switch moves cursor left/right
// - vertical raises/lowers gain, toggles on/off items
// - gain live immediately, stored on yes or by a remote control write
// - gain steps 0.5, 1 or 10 dB
// - yes commits, no restores prior settings
// - return item or last item opens save prompt
// - alarm whenever pll_unlock reports loss of lock; ref_locked does not raise it
// - remote led lit while remote selected
// - internal mode selects internal oscillator, int tag
// - external mode selects external input, ext tag
// - auto uses external while level good
// - auto falls to internal below -1 dBm
// - external frequency choice 10 or 25 MHz
// - normal display shows oven, lock, unlock code
// - mode 0 internal, 1 external, 2 auto
module fpm_ctrl
  import fpm_pkg::*;
#(
  parameter int TMO_CYC = TIMEOUT_CYC,
  parameter int DB_CYC = DEB_CYC,
  parameter int PH_CYC = PHASE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [4:0] sw_raw,
  input wire logic pll_unlock,
  input wire logic ext_level_ok,
  input wire logic ext_level_low,
  input wire logic oven_warm,
  input wire logic ref_locked,
  input wire logic uart_rxd,
  output logic uart_txd,
  input wire logic [S_W-1:0] nv_rdata,
  output logic [S_W-1:0] nv_wdata,
  output logic nv_wr,
  output logic [8:0] gain_out,
  output logic ref_sel_ext,
  output logic ext_freq_25,
  output logic [1:0] ref_tag,
  output logic [1:0] stat_code,
  output logic [2:0] disp_phase,
  output logic [1:0] menu_item,
  output logic [1:0] cursor,
  output logic save_yes,
  output logic alarm_led,
  output logic remote_led,
  output logic power_led
);
  // ==========================================================================
  // input synchronisers
  localparam int NS = 11;
  logic [NS-1:0] sync1_r, sync2_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // serial line resets at its idle mark, so no false start bit follows reset
      sync1_r <= {1'b1, {(NS-1){1'b0}}};
      sync2_r <= {1'b1, {(NS-1){1'b0}}};
    end else begin
      sync1_r <= {uart_rxd, ref_locked, oven_warm, ext_level_low, ext_level_ok, pll_unlock, sw_raw};
      sync2_r <= sync1_r;
    end
  end
  logic pll_s, lvl_ok_s, lvl_low_s, warm_s, lock_s, rxd_s;
  assign {rxd_s, lock_s, warm_s, lvl_low_s, lvl_ok_s, pll_s} = sync2_r[NS-1:5];

  // ==========================================================================
  // switch debounce: bit 0 menu, 1 left, 2 right, 3 up, 4 down
  logic [4:0] ev;
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_deb
      logic [19:0] cnt_r;
      logic stab_r;
      // a press must hold for the full window, so contact chatter gives no event
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt_r <= '0;
          stab_r <= 1'b0;
        end else if (sync2_r[gi] == stab_r) begin
          cnt_r <= '0;
        end else if (cnt_r == 20'(DB_CYC - 1)) begin
          cnt_r <= '0;
          stab_r <= sync2_r[gi];
        end else begin
          cnt_r <= cnt_r + 20'h00001;
        end
      end
      assign ev[gi] = (sync2_r[gi] != stab_r) && (cnt_r == 20'(DB_CYC - 1)) && !stab_r;
    end
  endgenerate

  // ==========================================================================
  // gain step helper
  function automatic logic [8:0] gain_step(input logic [8:0] g, input logic up,
                                           input logic [1:0] dig);
    logic [8:0] st;
    st = (dig == 2'h0) ? STEP_D0 : (dig == 2'h1) ? STEP_D1 : STEP_D2;
    if (up) begin
      gain_step = (g > GAIN_MAX - st) ? GAIN_MAX : g + st;
    end else begin
      gain_step = (g < st) ? 9'h000 : g - st;
    end
  endfunction : gain_step

  // ==========================================================================
  // menu state machine and settings
  fpm_st_t st_r;
  fpm_item_t item_r;
  logic [1:0] cur_r;
  logic yes_r;
  logic [S_W-1:0] set_r, edt_r;
  logic [29:0] tmo_r;
  logic [24:0] ph_r;
  logic boot_ld_r;
  logic apb_wr, ctrl_wr, tx_wr, rx_rd;
  logic tmo_hit, sess;
  assign sess = (st_r == ST_EDIT) || (st_r == ST_SAVE);
  assign tmo_hit = sess && (tmo_r == 30'(TMO_CYC - 1));
  assign ctrl_wr = apb_wr && (paddr == OFS_CTRL) && set_r[S_REM_BIT] && !sess;

  // inactivity timer, cleared by any switch event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmo_r <= '0;
    end else if (!sess || (ev != 5'h00) || tmo_hit) begin
      tmo_r <= '0;
    end else begin
      tmo_r <= tmo_r + 30'h00000001;
    end
  end

  // power-up phase timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_r <= '0;
    end else if (st_r == ST_BOOT_ALL || st_r == ST_BOOT_VER) begin
      ph_r <= (ph_r == 25'(PH_CYC - 1)) ? 25'h0000000 : ph_r + 25'h0000001;
    end else begin
      ph_r <= '0;
    end
  end

  // main sequencer: edits land in edt_r live, set_r is the committed copy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= ST_BOOT_ALL;
      item_r <= IT_GAIN;
      cur_r <= 2'h0;
      yes_r <= 1'b0;
      set_r <= '0;
      edt_r <= '0;
      boot_ld_r <= 1'b1;
      nv_wr <= 1'b0;
      nv_wdata <= '0;
    end else begin
      nv_wr <= 1'b0;
      boot_ld_r <= 1'b0;
      if (boot_ld_r) begin
        set_r <= nv_rdata;
        edt_r <= nv_rdata;
      end
      case (st_r)
        ST_BOOT_ALL: if (ph_r == 25'(PH_CYC - 1)) st_r <= ST_BOOT_VER;
        ST_BOOT_VER: if (ph_r == 25'(PH_CYC - 1)) st_r <= ST_NORMAL;
        ST_NORMAL: begin
          if (ev[0]) begin
            st_r <= ST_EDIT;
            item_r <= IT_GAIN;
            cur_r <= 2'h0;
          end else if (ctrl_wr) begin
            set_r <= pwdata[S_W-1:0];
            edt_r <= pwdata[S_W-1:0];
            nv_wdata <= pwdata[S_W-1:0];
            nv_wr <= 1'b1;
          end
        end
        ST_EDIT: begin
          if (tmo_hit) begin
            st_r <= ST_NORMAL;
            edt_r <= set_r;
          end else if (ev[0]) begin
            if (cur_r == CUR_RET || item_r == IT_REM) begin
              st_r <= ST_SAVE;
              yes_r <= 1'b1;
            end else begin
              item_r <= fpm_item_t'(item_r + 2'h1);
              cur_r <= 2'h0;
            end
          end else if (ev[1]) begin
            cur_r <= (cur_r == 2'h0) ? 2'h0 : cur_r - 2'h1;
          end else if (ev[2]) begin
            cur_r <= (cur_r == CUR_RET) ? CUR_RET : cur_r + 2'h1;
          end else if ((ev[3] || ev[4]) && cur_r != CUR_RET) begin
            case (item_r)
              IT_GAIN: edt_r[S_GAIN_LSB +: 9] <= gain_step(edt_r[S_GAIN_LSB +: 9], ev[3],
                                                           cur_r);
              IT_MODE: edt_r[S_MODE_LSB +: 2] <= (edt_r[S_MODE_LSB +: 2] == MODE_AUTO) ?
                                                 MODE_INT : edt_r[S_MODE_LSB +: 2] + 2'h1;
              IT_FREQ: edt_r[S_FREQ_BIT] <= !edt_r[S_FREQ_BIT];
              IT_REM: edt_r[S_REM_BIT] <= !edt_r[S_REM_BIT];
              default: edt_r <= edt_r;
            endcase
          end
        end
        ST_SAVE: begin
          if (tmo_hit) begin
            st_r <= ST_NORMAL;
            edt_r <= set_r;
          end else if (ev[3] || ev[4]) begin
            yes_r <= !yes_r;
          end else if (ev[0]) begin
            st_r <= ST_NORMAL;
            if (yes_r) begin
              set_r <= edt_r;
              nv_wdata <= edt_r;
              nv_wr <= 1'b1;
            end else begin
              edt_r <= set_r;
            end
          end
        end
        default: st_r <= ST_NORMAL;
      endcase
    end
  end

  // ==========================================================================
  // reference selection and indicators
  logic auto_ext_r;
  logic [1:0] mode;
  assign mode = edt_r[S_MODE_LSB +: 2];
  // hysteresis: stay external until the level falls below the low threshold
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_ext_r <= 1'b0;
    end else if (lvl_low_s) begin
      auto_ext_r <= 1'b0;
    end else if (lvl_ok_s) begin
      auto_ext_r <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_sel_ext <= 1'b0;
      ref_tag <= TAG_INT;
      stat_code <= CODE_OVEN;
      alarm_led <= 1'b0;
      remote_led <= 1'b0;
      power_led <= 1'b0;
      gain_out <= '0;
      ext_freq_25 <= 1'b0;
    end else begin
      case (mode)
        MODE_INT: begin
          ref_sel_ext <= 1'b0;
          ref_tag <= TAG_INT;
        end
        MODE_EXT: begin
          ref_sel_ext <= 1'b1;
          ref_tag <= TAG_EXT;
        end
        default: begin
          ref_sel_ext <= auto_ext_r;
          ref_tag <= auto_ext_r ? TAG_AUTO_E : TAG_AUTO_I;
        end
      endcase
      stat_code <= !warm_s ? CODE_OVEN : lock_s ? CODE_LOCK : CODE_UNLOCK;
      alarm_led <= pll_s;
      remote_led <= edt_r[S_REM_BIT];
      power_led <= 1'b1;
      gain_out <= edt_r[S_GAIN_LSB +: 9];
      ext_freq_25 <= edt_r[S_FREQ_BIT] && (mode != MODE_INT);
    end
  end
  assign disp_phase = st_r;
  assign menu_item = item_r;
  assign cursor = cur_r;
  assign save_yes = yes_r;

  // ==========================================================================
  // serial transmitter and receiver, fixed 8N1 at the set baud
  logic [11:0] tcnt_r, rcnt_r;
  logic [9:0] tsh_r;
  logic [3:0] tbit_r, rbit_r;
  logic rbusy_r, rx_val_r;
  logic [7:0] rsh_r, rx_data_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tsh_r <= '0;
      tbit_r <= '0;
      tcnt_r <= '0;
      uart_txd <= 1'b1;
    end else if (tbit_r == 4'h0) begin
      uart_txd <= 1'b1;
      if (tx_wr) begin
        tsh_r <= {1'b1, pwdata[7:0], 1'b0};
        tbit_r <= 4'hb; // extra slot keeps busy through the full stop bit
        tcnt_r <= '0;
      end
    end else if (tcnt_r == 12'h000) begin
      uart_txd <= tsh_r[0];
      tsh_r <= {1'b1, tsh_r[9:1]};
      tbit_r <= tbit_r - 4'h1;
      tcnt_r <= 12'(BAUD_CYC - 1);
    end else begin
      tcnt_r <= tcnt_r - 12'h001;
    end
  end

  // receiver samples mid-bit; a bad stop bit drops the byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rbusy_r <= 1'b0;
      rcnt_r <= '0;
      rbit_r <= '0;
      rsh_r <= '0;
      rx_data_r <= '0;
      rx_val_r <= 1'b0;
    end else begin
      if (rx_rd) rx_val_r <= 1'b0;
      if (!rbusy_r) begin
        if (!rxd_s) begin
          rbusy_r <= 1'b1;
          rcnt_r <= 12'(BAUD_CYC / 2);
          rbit_r <= '0;
        end
      end else if (rcnt_r != 12'h000) begin
        rcnt_r <= rcnt_r - 12'h001;
      end else begin
        rcnt_r <= 12'(BAUD_CYC - 1);
        rbit_r <= rbit_r + 4'h1;
        if (rbit_r == 4'h0 && rxd_s) rbusy_r <= 1'b0;
        if (rbit_r >= 4'h1 && rbit_r <= 4'h8) rsh_r <= {rxd_s, rsh_r[7:1]};
        if (rbit_r == 4'h9) begin
          rbusy_r <= 1'b0;
          if (rxd_s) begin
            rx_data_r <= rsh_r;
            rx_val_r <= 1'b1; // set wins over read clear
          end
        end
      end
    end
  end

  // ==========================================================================
  // apb slave, zero wait states, read data captured in setup
  logic mapped;
  assign mapped = (paddr == OFS_CTRL) || (paddr == OFS_STAT) || (paddr == OFS_TXD) ||
                  (paddr == OFS_RXD);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign apb_wr = psel && penable && pwrite && mapped;
  assign tx_wr = apb_wr && (paddr == OFS_TXD);
  assign rx_rd = psel && penable && !pwrite && (paddr == OFS_RXD);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        OFS_CTRL: prdata <= {19'h00000, set_r};
        OFS_STAT: prdata <= {17'h00000, rbusy_r, (tbit_r != 4'h0), ref_tag, stat_code,
                             alarm_led, ref_sel_ext, st_r, item_r, cur_r};
        OFS_RXD: prdata <= {23'h000000, rx_val_r, rx_data_r};
        default: prdata <= '0;
      endcase
    end
  end

  // ==========================================================================
  // checks
  chk_alarm_follow: assert property (@(posedge pclk) disable iff (!presetn)
    pll_s |=> alarm_led) else $error("alarm not raised on unlock");
  chk_remote_led: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(edt_r[S_REM_BIT]) |=> remote_led == $past(edt_r[S_REM_BIT]))
    else $error("remote led wrong");
  chk_int_select: assert property (@(posedge pclk) disable iff (!presetn)
    mode == MODE_INT |=> !ref_sel_ext && ref_tag == TAG_INT)
    else $error("internal mode not internal");
  chk_ext_select: assert property (@(posedge pclk) disable iff (!presetn)
    mode == MODE_EXT |=> ref_sel_ext) else $error("external mode not external");
  chk_auto_fall: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == MODE_AUTO && lvl_low_s) [*2] |=> !ref_sel_ext && ref_tag == TAG_AUTO_I)
    else $error("auto did not fall back");
  chk_save_commit: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == ST_SAVE && ev[0] && yes_r && !tmo_hit && !ev[3] && !ev[4]
    |=> nv_wr && set_r == $past(edt_r))
    else $error("yes did not commit");
  chk_no_store: assert property (@(posedge pclk) disable iff (!presetn)
    !(st_r == ST_SAVE && ev[0]) && !ctrl_wr && !boot_ld_r |=> !nv_wr && $stable(set_r))
    else $error("settings stored outside save");
  chk_timeout_abort: assert property (@(posedge pclk) disable iff (!presetn)
    tmo_hit |=> st_r == ST_NORMAL && edt_r == $past(set_r))
    else $error("timeout did not restore");
  chk_gain_live: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == ST_EDIT |=> ##1 gain_out == $past(edt_r[S_GAIN_LSB +: 9]))
    else $error("gain not live");
  chk_gain_range: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == ST_EDIT |-> edt_r[S_GAIN_LSB +: 9] <= GAIN_MAX || boot_ld_r)
    else $error("gain out of range");
  chk_timer_restart: assert property (@(posedge pclk) disable iff (!presetn)
    sess && ev != 5'h00 |=> tmo_r == 30'h00000000) else $error("timer kept running");
  cov_commit: cover property (@(posedge pclk) st_r == ST_SAVE && ev[0] && yes_r);
  cov_timeout: cover property (@(posedge pclk) tmo_hit);
  cov_auto_fall: cover property (@(posedge pclk) mode == MODE_AUTO && $fell(auto_ext_r));
  cov_rx_byte: cover property (@(posedge pclk) $rose(rx_val_r));
endmodule : fpm_ctrl

// >>> core/fpm_pkg.sv
// shared constants and types for the front panel menu and reference controller
package fpm_pkg;
  // ==========================================================================
  // clock and timing
  localparam int CLK_HZ = 25_000_000;
  localparam int BAUD = 9600;
  localparam int BAUD_CYC = CLK_HZ / BAUD;
  localparam int TIMEOUT_S = 30;
  localparam int TIMEOUT_CYC = TIMEOUT_S * CLK_HZ;
  localparam int DEB_MS = 10;
  localparam int DEB_CYC = DEB_MS * (CLK_HZ / 1000);
  localparam int PHASE_MS = 1000;
  localparam int PHASE_CYC = PHASE_MS * (CLK_HZ / 1000);
  // ==========================================================================
  // apb register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_TXD = 8'h08;
  localparam logic [7:0] OFS_RXD = 8'h0c;
  // ==========================================================================
  // settings word layout and values
  localparam int S_GAIN_LSB = 0;
  localparam int S_MODE_LSB = 9;
  localparam int S_FREQ_BIT = 11;
  localparam int S_REM_BIT = 12;
  localparam int S_W = 13;
  localparam logic [8:0] GAIN_MAX = 9'h0c8;
  localparam logic [1:0] MODE_INT = 2'h0;
  localparam logic [1:0] MODE_EXT = 2'h1;
  localparam logic [1:0] MODE_AUTO = 2'h2;
  // gain steps in half-dB units: 0.5, 1 and 10 dB
  localparam logic [8:0] STEP_D0 = 9'h001;
  localparam logic [8:0] STEP_D1 = 9'h002;
  localparam logic [8:0] STEP_D2 = 9'h014;
  localparam logic [1:0] CUR_RET = 2'h3;
  // ==========================================================================
  // enumerations
  typedef enum logic [2:0] {ST_BOOT_ALL, ST_BOOT_VER, ST_NORMAL, ST_EDIT, ST_SAVE} fpm_st_t;
  typedef enum logic [1:0] {IT_GAIN, IT_MODE, IT_FREQ, IT_REM} fpm_item_t;
  typedef enum logic [1:0] {CODE_OVEN, CODE_LOCK, CODE_UNLOCK} fpm_code_t;
  typedef enum logic [1:0] {TAG_INT, TAG_EXT, TAG_AUTO_E, TAG_AUTO_I} fpm_tag_t;
endpackage : fpm_pkg

// >>> dv/fpm_operator.sv
// operator and remote controller model: switches and serial link
module fpm_operator
  import fpm_pkg::*;
(
  input wire logic pclk,
  output logic [4:0] sw_raw,
  output logic uart_rxd,
  input wire logic uart_txd
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // idle levels: switches open, serial line at mark
  initial begin
    sw_raw = 5'h00;
    uart_rxd = 1'b1;
  end
  // one actuation, held well past the debounce window, then released
  task automatic press(input int k, input int hold = 10);
    @(posedge pclk) sw_raw[k] <= 1'b1;
    repeat (hold) @(posedge pclk);
    sw_raw[k] <= 1'b0;
    repeat (10) @(posedge pclk);
  endtask : press
  // start bit, eight data bits lsb first, one stop bit, no parity
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge pclk) uart_rxd <= f[i];
      repeat (BAUD_CYC - 1) @(posedge pclk);
    end
  endtask : send_byte
  // samples mid-bit; a missing start or bad stop bit clears ok
  task automatic recv_byte(output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    while (uart_txd !== 1'b0 && n < 4 * BAUD_CYC) begin
      @(posedge pclk);
      n++;
    end
    repeat (BAUD_CYC / 2) @(posedge pclk);
    ok = uart_txd === 1'b0;
    for (int i = 0; i < 8; i++) begin
      repeat (BAUD_CYC) @(posedge pclk);
      b[i] = uart_txd;
    end
    repeat (BAUD_CYC) @(posedge pclk);
    ok = ok && (uart_txd === 1'b1);
  endtask : recv_byte
endmodule : fpm_operator

// >>> dv/tb.sv
// self-checking bench for the front panel menu and reference controller
module tb
  import fpm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TMO = 2000;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, uart_rxd, uart_txd;
  logic pll_unlock, ext_level_ok, ext_level_low, oven_warm, ref_locked, nv_wr;
  logic ref_sel_ext, ext_freq_25, save_yes, alarm_led, remote_led, power_led, er, ok;
  logic [7:0] paddr, b;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0] sw_raw;
  logic [S_W-1:0] nv_rdata, nv_wdata, nv_last;
  logic [8:0] gain_out;
  logic [1:0] ref_tag, stat_code, menu_item, cursor;
  logic [2:0] disp_phase;
  int mismatches, samples_checked, cyc, nv_cnt, n0;
  // ==========================================================================
  // design and operator model
  fpm_ctrl #(.TMO_CYC(TMO), .DB_CYC(4), .PH_CYC(10)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sw_raw(sw_raw), .pll_unlock(pll_unlock), .ext_level_ok(ext_level_ok),
    .ext_level_low(ext_level_low), .oven_warm(oven_warm), .ref_locked(ref_locked),
    .uart_rxd(uart_rxd), .uart_txd(uart_txd), .nv_rdata(nv_rdata), .nv_wdata(nv_wdata),
    .nv_wr(nv_wr), .gain_out(gain_out), .ref_sel_ext(ref_sel_ext),
    .ext_freq_25(ext_freq_25), .ref_tag(ref_tag), .stat_code(stat_code),
    .disp_phase(disp_phase), .menu_item(menu_item), .cursor(cursor), .save_yes(save_yes),
    .alarm_led(alarm_led), .remote_led(remote_led), .power_led(power_led));
  fpm_operator u_op (.pclk(pclk), .sw_raw(sw_raw), .uart_rxd(uart_rxd), .uart_txd(uart_txd));
  // ==========================================================================
  // clock, store-write monitor and hang limit
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (nv_wr === 1'b1) begin
      nv_cnt++;
      nv_last = nv_wdata;
    end
    cyc++;
    if (cyc == 80000) begin
      mismatches++;
      stop_test();
    end
  end
  // ==========================================================================
  // shared tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only pready seen high ends this wait; if it never rises, the bench hang limit stops the run
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic step(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask : step
  task automatic op(input int k);
    u_op.press(k);
    @(negedge pclk);
  endtask : op
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  // ==========================================================================
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, pll_unlock, ext_level_low} = '0;
    {oven_warm, ref_locked, mismatches, samples_checked, cyc, nv_cnt} = '0;
    ext_level_ok = 1'b1;
    nv_rdata = 13'h0414; // 10 dB, auto mode
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    step(3);
    chk("phase", 0, 32'(disp_phase));
    step(12);
    chk("phase", 1, 32'(disp_phase));
    step(12);
    chk("phase", 2, 32'(disp_phase));
    chk("gain", 32'h14, 32'(gain_out));
    chk("power", 1, 32'(power_led));
    chk("ref", 32'h5, {ref_tag, ref_sel_ext});
    chk("stat", 0, 32'(stat_code));
    @(posedge pclk) {oven_warm, ref_locked, pll_unlock} <= 3'h7;
    step(5);
    chk("stat", 1, 32'(stat_code));
    chk("alarm", 1, 32'(alarm_led));
    @(posedge pclk) {ref_locked, pll_unlock, ext_level_ok, ext_level_low} <= 4'h1;
    step(5);
    chk("stat", 2, 32'(stat_code));
    chk("alarm", 0, 32'(alarm_led));
    chk("ref", 32'h6, {ref_tag, ref_sel_ext});
    @(posedge pclk) {ext_level_ok, ext_level_low} <= 2'h2;
    step(5);
    chk("ref", 32'h5, {ref_tag, ref_sel_ext});
    // a press one cycle short of the debounce window gives no event
    u_op.press(0, 3);
    step(1);
    chk("glitch", 2, 32'(disp_phase));
    // edit gain on every digit, then answer no
    n0 = nv_cnt;
    op(0);
    chk("edit", 32'h30, {disp_phase, menu_item, cursor});
    op(3);
    chk("gain", 32'h15, 32'(gain_out));
    op(2);
    chk("cursor", 1, 32'(cursor));
    op(3);
    op(2);
    op(3);
    chk("gain", 32'h2b, 32'(gain_out));
    op(4);
    chk("gain", 32'h17, 32'(gain_out));
    op(1);
    chk("cursor", 1, 32'(cursor));
    op(2);
    op(2);
    op(0);
    chk("save", 32'h9, {disp_phase, save_yes});
    op(4);
    chk("yes", 0, 32'(save_yes));
    op(0);
    step(3);
    chk("gain", 32'h14, 32'(gain_out));
    chk("nvwr", n0, nv_cnt);
    // edit and answer yes
    op(0);
    op(3);
    op(2);
    op(2);
    op(2);
    op(0);
    op(0);
    step(3);
    chk("nvwr", n0 + 1, nv_cnt);
    chk("nvdata", 32'h415, 32'(nv_last));
    apb(1'b0, OFS_CTRL, 0);
    chk("ctrl", 32'h415, rd);
    // idle timeout, restarted by each event
    op(0);
    op(3);
    step(1500);
    op(3);
    chk("gain", 32'h17, 32'(gain_out));
    step(1500);
    chk("phase", 3, 32'(disp_phase));
    step(700);
    chk("phase", 2, 32'(disp_phase));
    chk("gain", 32'h15, 32'(gain_out));
    chk("nvwr", n0 + 1, nv_cnt);
    // local-only control refuses remote writes; then select int mode and remote
    apb(1'b1, OFS_CTRL, 0);
    apb(1'b0, OFS_CTRL, 0);
    chk("ctrl", 32'h415, rd);
    op(0);
    op(0);
    chk("item", 1, 32'(menu_item));
    op(3);
    op(0);
    op(0);
    op(3);
    op(0);
    op(0);
    step(3);
    chk("nvdata", 32'h1015, 32'(nv_last));
    chk("rled", 1, 32'(remote_led));
    chk("ref", 0, {ext_freq_25, ref_tag, ref_sel_ext});
    // remote writes: external 25 MHz, then auto with a weak input
    @(posedge pclk) ext_level_low <= 1'b1;
    apb(1'b1, OFS_CTRL, 32'h1a15);
    step(3);
    chk("nvdata", 32'h1a15, 32'(nv_last));
    chk("ref", 32'hb, {ext_freq_25, ref_tag, ref_sel_ext});
    apb(1'b1, OFS_CTRL, 32'h1c15);
    step(5);
    chk("ref", 32'he, {ext_freq_25, ref_tag, ref_sel_ext});
    apb(1'b0, 8'h10, 0);
    chk("unmapped", 32'h1, {rd[30:0], er});
    // serial both ways
    apb(1'b1, OFS_TXD, 32'ha5);
    u_op.recv_byte(b, ok);
    chk("txbyte", 32'h1a5, {ok, b});
    u_op.send_byte(8'h3c);
    apb(1'b0, OFS_RXD, 0);
    chk("rxd", 32'h13c, rd);
    apb(1'b0, OFS_RXD, 0);
    chk("rxvalid", 0, 32'(rd[8]));
    apb(1'b0, OFS_STAT, 0);
    chk("status", 32'h1c2c, rd);
    stop_test();
  end
endmodule : tb
